/* rtl/serial_unit_pkg.sv */
package serial_unit_pkg;

  // Register addresses
  localparam logic [15:0] MODE_ADDR = 16'hff70;
  localparam logic [15:0] ERR_ADDR = 16'hff73;
  localparam logic [15:0] TXS_ADDR = 16'hff74;
  localparam logic [15:0] RXB_ADDR = 16'hff75;

  // Mode register layout
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam int POWER_BIT = 7;
  localparam int TXE_BIT = 6;
  localparam int RXE_BIT = 5;
  localparam int PS_HI_BIT = 4;
  localparam int PS_LO_BIT = 3;
  localparam int CL_BIT = 2;
  localparam int SL_BIT = 1;

  // Error status layout
  localparam int PE_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int OVE_BIT = 0;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // Parity select encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [4:0] HALF_TICKS_RESET = 5'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_START, S_DATA, S_PARITY, S_STOP
  } frame_state_t;

endpackage

/* rtl/async_serial_unit.sv */
`timescale 1ns/1ps
module async_serial_unit #(
  parameter int RX_DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic baud_tick_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n_out,
  output logic rx_pin_owned_out,
  output logic transmit_done_irq_out,
  output logic receive_done_irq_out,
  output logic tx_busy_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in
);

  ////////////////////////////////////////////////////////////////////////
  // Mode register

  logic [7:0] mode_q;
  logic power, tx_on, rx_on;
  logic [1:0] par_sel;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= serial_unit_pkg::MODE_RESET;
    end else if (wr_en_in && addr_in == serial_unit_pkg::MODE_ADDR) begin
      mode_q <= {wdata_in[7:1], 1'b1};
    end
  end

  assign power = mode_q[serial_unit_pkg::POWER_BIT];
  assign tx_on = power && mode_q[serial_unit_pkg::TXE_BIT];
  assign rx_on = power && mode_q[serial_unit_pkg::RXE_BIT];
  assign par_sel = {mode_q[serial_unit_pkg::PS_HI_BIT], mode_q[serial_unit_pkg::PS_LO_BIT]};

  // Power off is modelled as a held synchronous clear; the clock itself is never gated
  function automatic logic parity_of(input logic [7:0] d, input logic eight);
    parity_of = eight ? ^d : ^d[6:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input pin synchroniser

  logic rx_meta_q, rx_sync_q, rx_line;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_in_pin_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  assign rx_line = power ? rx_sync_q : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  serial_unit_pkg::frame_state_t tx_state_q;
  logic [7:0] tx_shift_q;
  logic [3:0] tx_cnt_q;
  logic tx_line_q, tx_par_q, tx_done_q;
  logic tx_write;
  logic tx_eight, tx_two_stop;

  assign tx_write = wr_en_in && addr_in == serial_unit_pkg::TXS_ADDR;
  assign tx_eight = mode_q[serial_unit_pkg::CL_BIT];
  assign tx_two_stop = mode_q[serial_unit_pkg::SL_BIT];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_q <= serial_unit_pkg::S_IDLE;
      tx_shift_q <= 8'h00;
      tx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
      tx_line_q <= 1'b1;
      tx_par_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else if (!tx_on) begin
      tx_state_q <= serial_unit_pkg::S_IDLE;
      tx_shift_q <= 8'h00;
      tx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
      tx_line_q <= 1'b1;
      tx_par_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      unique case (tx_state_q)
        serial_unit_pkg::S_IDLE: begin
          tx_line_q <= 1'b1;
          if (tx_write) begin
            tx_shift_q <= wdata_in;
            unique case (par_sel)
              serial_unit_pkg::PAR_EVEN: tx_par_q <= parity_of(wdata_in, tx_eight);
              serial_unit_pkg::PAR_ODD: tx_par_q <= ~parity_of(wdata_in, tx_eight);
              serial_unit_pkg::PAR_ZERO: tx_par_q <= 1'b0;
              serial_unit_pkg::PAR_NONE: tx_par_q <= 1'b0;
            endcase
            tx_state_q <= serial_unit_pkg::S_START;
          end
        end
        serial_unit_pkg::S_START: begin
          if (baud_tick_in) begin
            tx_line_q <= 1'b0;
            tx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
            tx_state_q <= serial_unit_pkg::S_DATA;
          end
        end
        serial_unit_pkg::S_DATA: begin
          if (baud_tick_in) begin
            tx_line_q <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == (tx_eight ? 4'h7 : 4'h6)) begin
              tx_state_q <= par_sel == serial_unit_pkg::PAR_NONE ?
                serial_unit_pkg::S_STOP : serial_unit_pkg::S_PARITY;
              tx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
            end
          end
        end
        serial_unit_pkg::S_PARITY: begin
          if (baud_tick_in) begin
            tx_line_q <= tx_par_q;
            tx_state_q <= serial_unit_pkg::S_STOP;
          end
        end
        serial_unit_pkg::S_STOP: begin
          if (baud_tick_in) begin
            if (tx_cnt_q == (tx_two_stop ? 4'h2 : 4'h1)) begin
              // Final stop period has elapsed
              tx_done_q <= 1'b1;
              tx_state_q <= serial_unit_pkg::S_IDLE;
            end else begin
              tx_line_q <= 1'b1;
              tx_cnt_q <= tx_cnt_q + 4'h1;
            end
          end
        end
        default: tx_state_q <= serial_unit_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver, runs beside the transmitter

  serial_unit_pkg::frame_state_t rx_state_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  logic [4:0] rx_tick_q;
  logic rx_par_acc_q, rx_frame_q, rx_pe_q;
  logic [2:0] err_q;
  logic rx_mid;
  logic err_read;

  // Sampling lands on the second tick of each bit; the tick is taken as twice the bit rate
  assign rx_mid = baud_tick_in && rx_tick_q[0];
  assign err_read = rd_en_in && addr_in == serial_unit_pkg::ERR_ADDR;

  // Two-entry buffer between the receiver and the consumer
  logic [7:0] buf_mem [RX_DEPTH];
  logic [1:0] buf_cnt_q;
  logic buf_wp_q, buf_rp_q;
  logic buf_push, buf_pop, buf_full;

  assign buf_full = buf_cnt_q == 2'(RX_DEPTH);
  assign buf_pop = rx_valid_out && rx_ready_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_state_q <= serial_unit_pkg::S_IDLE;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
      rx_tick_q <= serial_unit_pkg::HALF_TICKS_RESET;
      rx_par_acc_q <= 1'b0;
      rx_frame_q <= 1'b0;
      rx_pe_q <= 1'b0;
    end else if (!rx_on) begin
      rx_state_q <= serial_unit_pkg::S_IDLE;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
      rx_tick_q <= serial_unit_pkg::HALF_TICKS_RESET;
      rx_par_acc_q <= 1'b0;
      rx_frame_q <= 1'b0;
      rx_pe_q <= 1'b0;
    end else begin
      rx_frame_q <= 1'b0;
      if (baud_tick_in) begin
        rx_tick_q <= rx_tick_q + 5'h1;
      end
      unique case (rx_state_q)
        serial_unit_pkg::S_IDLE: begin
          rx_tick_q <= serial_unit_pkg::HALF_TICKS_RESET;
          if (!rx_line) begin
            rx_state_q <= serial_unit_pkg::S_START;
          end
        end
        serial_unit_pkg::S_START: begin
          if (rx_mid) begin
            rx_cnt_q <= serial_unit_pkg::BIT_CNT_RESET;
            rx_par_acc_q <= 1'b0;
            rx_state_q <= rx_line ? serial_unit_pkg::S_IDLE : serial_unit_pkg::S_DATA;
          end
        end
        serial_unit_pkg::S_DATA: begin
          if (rx_mid) begin
            rx_shift_q <= tx_eight ? {rx_line, rx_shift_q[7:1]} : {1'b0, rx_line, rx_shift_q[6:1]};
            rx_par_acc_q <= rx_par_acc_q ^ rx_line;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == (tx_eight ? 4'h7 : 4'h6)) begin
              rx_state_q <= par_sel == serial_unit_pkg::PAR_NONE ?
                serial_unit_pkg::S_STOP : serial_unit_pkg::S_PARITY;
            end
          end
        end
        serial_unit_pkg::S_PARITY: begin
          if (rx_mid) begin
            unique case (par_sel)
              serial_unit_pkg::PAR_EVEN: rx_pe_q <= rx_par_acc_q ^ rx_line;
              serial_unit_pkg::PAR_ODD: rx_pe_q <= ~(rx_par_acc_q ^ rx_line);
              serial_unit_pkg::PAR_ZERO: rx_pe_q <= 1'b0;
              serial_unit_pkg::PAR_NONE: rx_pe_q <= 1'b0;
            endcase
            rx_state_q <= serial_unit_pkg::S_STOP;
          end
        end
        serial_unit_pkg::S_STOP: begin
          if (rx_mid) begin
            // Only the first stop bit is looked at
            rx_frame_q <= 1'b1;
            rx_cnt_q <= {3'h0, ~rx_line};
            rx_state_q <= serial_unit_pkg::S_IDLE;
          end
        end
        default: rx_state_q <= serial_unit_pkg::S_IDLE;
      endcase
    end
  end

  // Error flags: a new error wins over the clearing read
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_q <= serial_unit_pkg::ERR_RESET[2:0];
    end else if (!rx_on) begin
      err_q <= serial_unit_pkg::ERR_RESET[2:0];
    end else begin
      err_q <= (err_read ? 3'h0 : err_q) |
        (rx_frame_q ? {rx_pe_q && par_sel[1], rx_cnt_q[0], buf_full} : 3'h0);
    end
  end

  assign buf_push = rx_frame_q && !buf_full;

  always_ff @(posedge clk_in) begin
    if (buf_push) begin
      buf_mem[buf_wp_q] <= rx_shift_q;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      buf_cnt_q <= 2'h0;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
    end else if (!rx_on) begin
      buf_cnt_q <= 2'h0;
      buf_wp_q <= 1'b0;
      buf_rp_q <= 1'b0;
    end else begin
      buf_cnt_q <= buf_cnt_q + 2'(buf_push) - 2'(buf_pop);
      if (buf_push) begin
        buf_wp_q <= ~buf_wp_q;
      end
      if (buf_pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and read port

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      serial_out_pin_out <= 1'b1;
      serial_out_pin_oe_n_out <= 1'b1;
      rx_pin_owned_out <= 1'b0;
      transmit_done_irq_out <= 1'b0;
      receive_done_irq_out <= 1'b0;
      tx_busy_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      serial_out_pin_out <= tx_on ? tx_line_q : 1'b1;
      serial_out_pin_oe_n_out <= ~tx_on;
      rx_pin_owned_out <= rx_on;
      transmit_done_irq_out <= tx_done_q;
      receive_done_irq_out <= rx_frame_q;
      // Busy drops with the enable, so it never outlives the pin drive
      tx_busy_out <= tx_on && tx_state_q != serial_unit_pkg::S_IDLE;
      rx_valid_out <= (buf_cnt_q - 2'(buf_pop)) != 2'h0 || buf_push;
      rx_data_out <= buf_mem[buf_pop ? ~buf_rp_q : buf_rp_q];
      if (buf_cnt_q == 2'h0 || (buf_cnt_q == 2'h1 && buf_pop)) begin
        rx_data_out <= rx_shift_q;
      end
      if (!rx_on) begin
        rx_valid_out <= 1'b0;
      end
      unique case (addr_in)
        serial_unit_pkg::MODE_ADDR: rdata_out <= mode_q;
        serial_unit_pkg::ERR_ADDR: rdata_out <= {5'h0, err_q};
        serial_unit_pkg::RXB_ADDR: rdata_out <= rx_data_out;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

endmodule

/* sim/serial_unit_monitor.sv */
`timescale 1ns/1ps
module serial_unit_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic baud_tick_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] rdata_out,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe_n_out,
  input wire logic rx_pin_owned_out,
  input wire logic transmit_done_irq_out,
  input wire logic receive_done_irq_out,
  input wire logic tx_busy_out,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic rx_ready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start_wr;
    wr_en_in && addr_in == serial_unit_pkg::TXS_ADDR && !tx_busy_out && !serial_out_pin_oe_n_out;
  endsequence
  sequence s_done;
    transmit_done_irq_out ##1 !transmit_done_irq_out;
  endsequence
  property p_mode_bit0;
    rd_en_in && addr_in == serial_unit_pkg::MODE_ADDR |=> rdata_out[0];
  endproperty
  property p_start;
    s_start_wr |-> ##2 tx_busy_out && serial_out_pin_out;
  endproperty
  property p_drive;
    tx_busy_out |-> !serial_out_pin_oe_n_out;
  endproperty
  property p_idle;
    !tx_busy_out |-> serial_out_pin_out;
  endproperty
  // A bit reaches the port two cycles after the tick that launches it
  property p_hold;
    tx_busy_out && $past(tx_busy_out) && $changed(serial_out_pin_out) |-> $past(baud_tick_in, 2);
  endproperty
  property p_done;
    transmit_done_irq_out |-> serial_out_pin_out && ($past(baud_tick_in) || $past(baud_tick_in, 2))
      ##0 s_done;
  endproperty
  // A disable may empty the buffer, so only a live receiver must hold its word
  property p_rx_hold;
    rx_valid_out && !rx_ready_in && rx_pin_owned_out |=>
      !rx_pin_owned_out || (rx_valid_out && $stable(rx_data_out));
  endproperty
  property p_rx_off;
    !rx_pin_owned_out && !$past(rx_pin_owned_out) |-> !rx_valid_out && !receive_done_irq_out;
  endproperty
  a_mode_bit0: assert property (p_mode_bit0) else $error("mode bit 0 read as zero");
  a_start: assert property (p_start) else $error("frame did not start");
  a_drive: assert property (p_drive) else $error("busy without pin drive");
  a_idle: assert property (p_idle) else $error("idle line not high");
  a_hold: assert property (p_hold) else $error("bit changed between ticks");
  a_done: assert property (p_done) else $error("bad completion pulse");
  a_rx_hold: assert property (p_rx_hold) else $error("stalled word lost");
  a_rx_off: assert property (p_rx_off) else $error("receiver active while off");
endmodule

bind async_serial_unit serial_unit_monitor u_serial_unit_monitor (.clk_in, .resetn_in,
  .baud_tick_in, .wr_en_in, .rd_en_in, .addr_in, .rdata_out, .serial_out_pin_out,
  .serial_out_pin_oe_n_out, .rx_pin_owned_out, .transmit_done_irq_out, .receive_done_irq_out,
  .tx_busy_out, .rx_data_out, .rx_valid_out, .rx_ready_in);

/* sim/remote_serial_peer.sv */
`timescale 1ns/1ps
module remote_serial_peer (
  input wire logic clk_in,
  input wire logic tick_in,
  input wire logic send_in,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] par_in,
  input wire logic bad_par_in,
  output logic line_out,
  output logic busy_out
);
  logic bits_q [$];
  logic p;
  int i;
  // Two ticks per bit, as the receiver samples on every second tick
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in iff send_in);
      busy_out = 1'b1;
      p = (par_in == serial_unit_pkg::PAR_ZERO) ? 1'b0 : (par_in == serial_unit_pkg::PAR_ODD) ^ (^byte_in);
      bits_q = {1'b0};
      for (i = 0; i < 8; i++) bits_q.push_back(byte_in[i]);
      if (par_in != serial_unit_pkg::PAR_NONE) bits_q.push_back(p ^ bad_par_in);
      bits_q.push_back(1'b1);
      @(posedge clk_in iff tick_in);
      foreach (bits_q[k]) begin
        @(negedge clk_in);
        line_out = bits_q[k];
        repeat (2) @(posedge clk_in iff tick_in);
      end
      busy_out = 1'b0;
    end
  end
endmodule

/* sim/async_serial_uart_core_test.sv */
`timescale 1ns/1ps
module async_serial_uart_core_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic baud_tick_in = 1'b0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out, rx_data_out, rd_q;
  logic [7:0] pb = 8'h00;
  logic [1:0] ppar = 2'h0;
  logic psend = 1'b0;
  logic pbad = 1'b0;
  logic serial_in_pin_in, serial_out_pin_out, serial_out_pin_oe_n_out, rx_pin_owned_out;
  logic transmit_done_irq_out, receive_done_irq_out, tx_busy_out, rx_valid_out, pbusy;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int rx_done_cnt = 0;
  always #2 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    cyc++;
    baud_tick_in <= (cyc % 8 == 0);
    if (receive_done_irq_out === 1'b1) rx_done_cnt++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  async_serial_unit u_async_serial_unit (.clk_in, .resetn_in, .baud_tick_in, .wr_en_in,
    .rd_en_in, .addr_in, .wdata_in, .rdata_out, .serial_in_pin_in, .serial_out_pin_out,
    .serial_out_pin_oe_n_out, .rx_pin_owned_out, .transmit_done_irq_out,
    .receive_done_irq_out, .tx_busy_out, .rx_data_out, .rx_valid_out, .rx_ready_in);
  remote_serial_peer u_remote_serial_peer (.clk_in, .tick_in(baud_tick_in), .send_in(psend),
    .byte_in(pb), .par_in(ppar), .bad_par_in(pbad), .line_out(serial_in_pin_in),
    .busy_out(pbusy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge clk_in);
    wr_en_in = 1'b1;
    addr_in = a;
    wdata_in = d;
    @(negedge clk_in);
    wr_en_in = 1'b0;
  endtask
  task automatic rd(logic [15:0] a);
    @(negedge clk_in);
    rd_en_in = 1'b1;
    addr_in = a;
    @(negedge clk_in);
    rd_en_in = 1'b0;
    rd_q = rdata_out;
  endtask
  // Enables drop before power, format is set before power returns
  task automatic cfg(logic [7:0] m);
    wr(serial_unit_pkg::MODE_ADDR, 8'h81);
    wr(serial_unit_pkg::MODE_ADDR, m & 8'h1f);
    wr(serial_unit_pkg::MODE_ADDR, m & 8'h9f);
    wr(serial_unit_pkg::MODE_ADDR, m);
    rd(serial_unit_pkg::MODE_ADDR);
    check("mode", rd_q, m | 8'h01);
  endtask
  function automatic logic par_bit(logic [7:0] d, logic [1:0] p, logic len);
    logic x;
    x = len ? ^d : ^d[6:0];
    if (p == serial_unit_pkg::PAR_EVEN) return x;
    if (p == serial_unit_pkg::PAR_ODD) return ~x;
    return 1'b0;
  endfunction
  task automatic tx_frame(logic [7:0] d, logic [1:0] p, logic len, logic stop);
    logic exp_q [$];
    int n;
    exp_q = {1'b0};
    for (n = 0; n < 7 + len; n++) exp_q.push_back(d[n]);
    if (p != serial_unit_pkg::PAR_NONE) exp_q.push_back(par_bit(d, p, len));
    exp_q.push_back(1'b1);
    if (stop) exp_q.push_back(1'b1);
    wr(serial_unit_pkg::TXS_ADDR, d);
    foreach (exp_q[k]) begin
      @(posedge clk_in iff baud_tick_in);
      repeat (3) @(negedge clk_in);
      check("tx_bit", {7'h00, serial_out_pin_out}, {7'h00, exp_q[k]});
    end
    // No further character goes in before the completion pulse
    for (n = 0; n < 12 && transmit_done_irq_out !== 1'b1; n++) @(negedge clk_in);
    check("tx_done", {7'h00, transmit_done_irq_out}, 8'h01);
  endtask
  task automatic peer_send(logic [7:0] d, logic [1:0] p, logic bad);
    int n;
    @(negedge clk_in);
    pb = d;
    ppar = p;
    pbad = bad;
    psend = 1'b1;
    @(negedge clk_in);
    psend = 1'b0;
    for (n = 0; n < 400 && pbusy !== 1'b0; n++) @(negedge clk_in);
    repeat (20) @(negedge clk_in);
  endtask
  task automatic pop();
    rx_ready_in = 1'b1;
    @(negedge clk_in);
    rx_ready_in = 1'b0;
    @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [7:0] d;
    logic [1:0] p;
    d = 8'($urandom(56301));
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    rd(serial_unit_pkg::MODE_ADDR);
    check("mode_rst", rd_q, serial_unit_pkg::MODE_RESET);
    check("pins_stop", {6'h00, serial_out_pin_oe_n_out, rx_pin_owned_out}, 8'h02);
    wr(serial_unit_pkg::TXS_ADDR, 8'h5a);
    repeat (12) @(negedge clk_in);
    check("tx_off", {7'h00, tx_busy_out}, 8'h00);
    for (i = 0; i < 8; i++) begin
      cfg({3'b110, i[1:0], i[2], i[0] ^ i[1], 1'b0});
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      tx_frame(d, i[1:0], i[2], i[0] ^ i[1]);
    end
    cfg(8'hbc);
    for (i = 0; i < 3; i++) peer_send(8'h31 + 8'(i), serial_unit_pkg::PAR_EVEN, 1'b0);
    rd(serial_unit_pkg::ERR_ADDR);
    check("overrun", rd_q, 8'h01);
    check("rx_irqs", 8'(rx_done_cnt), 8'h03);
    rd(serial_unit_pkg::RXB_ADDR);
    check("rxb_read", rd_q, 8'h31);
    for (i = 0; i < 2; i++) begin
      check("rx_buf", rx_data_out, 8'h31 + 8'(i));
      pop();
    end
    check("rx_empty", {7'h00, rx_valid_out}, 8'h00);
    // Every parity mode, the parity slot corrupted in all but PAR_NONE, sent while transmitting
    for (i = 0; i < 4; i++) begin
      p = 2'(3 - i);
      cfg({3'b111, p, 3'b100});
      d = 8'($urandom);
      fork
        tx_frame(d, p, 1'b1, 1'b0);
        peer_send(d, p, 1'b1);
      join
      check("rx_data", rx_data_out, d);
      pop();
      rd(serial_unit_pkg::ERR_ADDR);
      check("parity_err", rd_q, {5'h00, p[1], 2'h0});
    end
    peer_send(8'h77, serial_unit_pkg::PAR_NONE, 1'b0);
    check("rx_wait", {7'h00, rx_valid_out}, 8'h01);
    check("pins_on", {6'h00, serial_out_pin_oe_n_out, rx_pin_owned_out}, 8'h01);
    wr(serial_unit_pkg::TXS_ADDR, 8'h00);
    repeat (20) @(negedge clk_in);
    wr(serial_unit_pkg::MODE_ADDR, 8'h84);
    repeat (3) @(negedge clk_in);
    check("tx_abort", {6'h00, tx_busy_out, serial_out_pin_out}, 8'h01);
    check("rx_abort", {7'h00, rx_valid_out}, 8'h00);
    wr(serial_unit_pkg::MODE_ADDR, 8'h04);
    rd(serial_unit_pkg::ERR_ADDR);
    check("err_off", rd_q, serial_unit_pkg::ERR_RESET);
    end_of_test();
  end
endmodule
